// *** verilog/pems_device.sv ***
// Amplifier power-down, error recovery, volume ramp and headphone switch sequencer
//
// A simple write-strobe register port on the link pins was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pems_device #(
   parameter int unsigned PD_DELAY_CYC = pems_pkg::PD_DELAY_CYC,
   parameter int unsigned STARTUP_CYC  = pems_pkg::STARTUP_CYC,
   parameter int unsigned ERR_HOLD_CYC = pems_pkg::ERR_HOLD_CYC,
   parameter int unsigned SW_UNIT_CYC  = pems_pkg::SW_UNIT_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Control pins
   pems_if.dev              link,
   // Chip-side status
   input  wire logic        frame_tick,
   input  wire logic [1:0]  rate_class,
   input  wire logic        gate_drive_supply_ok,
   input  wire logic        regulator_voltage_ok,
   input  wire logic        fault_event,
   input  wire logic        soft_mute,
   // Chip-side controls
   output logic             bridge_low_z,
   output logic             hp_outputs_enable,
   output logic             speaker_outputs_enable,
   output logic [11:0]      volume_level,
   output logic             ramp_busy
);
   // ----------------------------------------
   // Types and functions
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_OFF     = 3'h0,
      ST_START   = 3'h1,
      ST_RUN     = 3'h3,
      ST_PD_WAIT = 3'h2,
      ST_PD_OFF  = 3'h6,
      ST_ERR     = 3'h4
   } pems_seq_t;
   typedef enum logic [1:0] {
      HP_IDLE = 2'h0,
      HP_DOWN = 2'h1,
      HP_SW   = 2'h3,
      HP_UP   = 2'h2
   } pems_hp_t;

   function automatic logic [4:0] step_frames(input logic [1:0] rc);
      unique case (rc)
         pems_pkg::RATE_UPTO_48K: step_frames = pems_pkg::STEP_FR_LOW;
         pems_pkg::RATE_UPTO_96K: step_frames = pems_pkg::STEP_FR_MID;
         default:                 step_frames = pems_pkg::STEP_FR_HIGH;
      endcase
   endfunction : step_frames

   function automatic logic [31:0] sw_cycles(input logic [7:0] per);
      sw_cycles = 32'((33'(per) + 33'h1) * 33'(SW_UNIT_CYC));
   endfunction : sw_cycles

   // ----------------------------------------
   // Registers behind the device port
   // ----------------------------------------
   logic [7:0] hp_cfg_q;
   logic [7:0] vol_cfg_q;
   logic [7:0] ss_per_q;
   logic [7:0] rdata_q;
   wire  [7:0] rdata_d = (link.reg_addr == pems_pkg::REG_HP_CFG)     ? hp_cfg_q  :
                         (link.reg_addr == pems_pkg::REG_VOL_CFG)    ? vol_cfg_q :
                         (link.reg_addr == pems_pkg::REG_START_STOP) ? ss_per_q  : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_cfg_q  <= pems_pkg::HP_CFG_RST;
         vol_cfg_q <= pems_pkg::VOL_CFG_RST;
         ss_per_q  <= pems_pkg::START_STOP_RST;
         rdata_q   <= 8'h00;
      end else begin
         if (link.reg_we && link.reg_addr == pems_pkg::REG_HP_CFG)     hp_cfg_q  <= link.reg_wdata;
         if (link.reg_we && link.reg_addr == pems_pkg::REG_VOL_CFG)    vol_cfg_q <= link.reg_wdata;
         if (link.reg_we && link.reg_addr == pems_pkg::REG_START_STOP) ss_per_q  <= link.reg_wdata;
         rdata_q <= rdata_d;
      end
   end
   assign link.reg_rdata = rdata_q;

   // ----------------------------------------
   // Power sequencer
   // ----------------------------------------
   pems_seq_t   seq_q, seq_d;
   logic [31:0] cnt_q, cnt_d;
   logic        stage_en_q;
   logic        fault_oe_q;
   logic        low_z_q;
   wire         supplies_ok = gate_drive_supply_ok && regulator_voltage_ok;
   wire         pd_req      = !link.power_down_request_n;
   wire         err_req     = !link.back_end_error_n;
   wire         cnt_end_st  = cnt_q >= STARTUP_CYC - 1;
   wire         cnt_end_pd  = cnt_q >= PD_DELAY_CYC - 1;
   wire         cnt_end_err = cnt_q >= ERR_HOLD_CYC - 1;

   always_comb begin
      seq_d = seq_q;
      cnt_d = cnt_q + 32'h1;
      if (!link.reset_n) begin
         seq_d = ST_OFF;
         cnt_d = 32'h0;
      end else begin
         unique case (seq_q)
            ST_OFF: begin
               seq_d = pd_req ? ST_PD_OFF : ST_START;
               cnt_d = 32'h0;
            end
            ST_START: begin
               if (err_req) begin
                  seq_d = ST_ERR;
                  cnt_d = 32'h0;
               end else if (pd_req) begin
                  seq_d = ST_PD_OFF;
               end else if (cnt_end_st) begin
                  seq_d = ST_RUN;
               end
            end
            ST_RUN: begin
               cnt_d = 32'h0;
               if (err_req) seq_d = ST_ERR;
               else if (pd_req) seq_d = ST_PD_WAIT;
            end
            ST_PD_WAIT: begin
               if (err_req) begin
                  seq_d = ST_ERR;
                  cnt_d = 32'h0;
               end else if (cnt_end_pd) begin
                  seq_d = ST_PD_OFF;
               end
            end
            ST_PD_OFF: begin
               cnt_d = 32'h0;
               if (!pd_req) seq_d = ST_START;
            end
            ST_ERR: begin
               if (!cnt_end_err) begin
                  cnt_d = cnt_q + 32'h1;
               end else begin
                  cnt_d = cnt_q;
                  if (!err_req) begin
                     seq_d = pd_req ? ST_PD_OFF : ST_RUN;
                     cnt_d = 32'h0;
                  end
               end
            end
            default: begin
               seq_d = ST_OFF;
               cnt_d = 32'h0;
            end
         endcase
      end
   end

   wire stage_en_d = (seq_d == ST_RUN || seq_d == ST_PD_WAIT) && supplies_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q      <= ST_OFF;
         cnt_q      <= 32'h0;
         stage_en_q <= 1'b0;
         fault_oe_q <= 1'b0;
         low_z_q    <= 1'b1;
      end else begin
         seq_q      <= seq_d;
         cnt_q      <= cnt_d;
         stage_en_q <= stage_en_d;
         fault_oe_q <= link.reset_n && (fault_event || !supplies_ok);
         low_z_q    <= !supplies_ok;
      end
   end
   assign link.power_stage_enable = stage_en_q;
   assign link.fault_o            = 1'b0;
   assign link.fault_oe           = fault_oe_q;
   assign bridge_low_z            = low_z_q;

   // ----------------------------------------
   // Headphone select filter and switch-over
   // ----------------------------------------
   pems_hp_t    hp_q;
   logic        hp_sel_q;
   logic        hp_on_q;
   logic [7:0]  hp_flt_q;
   logic [31:0] sw_cnt_q;
   logic        hp_en_q;
   logic        spk_en_q;
   wire         hp_diff   = link.headphone_select != hp_sel_q;
   wire         hp_accept = hp_diff && (hp_flt_q >= 8'(pems_pkg::HP_PULSE_CYC - 1));
   wire         sw_done   = sw_cnt_q >= sw_cycles(ss_per_q) - 32'h1;

   // ----------------------------------------
   // Volume ramp
   // ----------------------------------------
   logic [11:0] vol_q;
   logic [4:0]  frm_q;
   logic        busy_q;
   wire  [11:0] vol_full = 12'(pems_pkg::VOL_STEPS_BASE << vol_cfg_q[1:0]);
   wire         mute     = soft_mute || hp_q == HP_DOWN || hp_q == HP_SW ||
                           seq_q != ST_RUN;
   wire  [11:0] vol_tgt  = mute ? 12'h000 : vol_full;
   wire         step_end = frame_tick && (frm_q >= step_frames(rate_class) - 5'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_q     <= HP_IDLE;
         hp_sel_q <= 1'b0;
         hp_on_q  <= 1'b0;
         hp_flt_q <= 8'h00;
         sw_cnt_q <= 32'h0;
         hp_en_q  <= 1'b0;
         spk_en_q <= 1'b0;
      end else begin
         hp_flt_q <= hp_diff ? hp_flt_q + 8'h1 : 8'h00;
         if (hp_accept) hp_sel_q <= link.headphone_select;
         unique case (hp_q)
            HP_IDLE: if (hp_sel_q != hp_on_q) hp_q <= HP_DOWN;
            HP_DOWN: begin
               sw_cnt_q <= 32'h0;
               if (vol_q == 12'h000) hp_q <= HP_SW;
            end
            HP_SW: begin
               sw_cnt_q <= sw_cnt_q + 32'h1;
               if (sw_done) begin
                  hp_on_q <= hp_sel_q;
                  hp_q    <= HP_UP;
               end
            end
            HP_UP: if (vol_q == vol_tgt) hp_q <= HP_IDLE;
         endcase
         hp_en_q  <= hp_on_q || !hp_cfg_q[pems_pkg::HP_DISABLE_BIT];
         spk_en_q <= !hp_on_q && stage_en_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vol_q  <= 12'h000;
         frm_q  <= 5'h00;
         busy_q <= 1'b0;
      end else begin
         busy_q <= vol_q != vol_tgt;
         if (vol_q == vol_tgt) begin
            frm_q <= 5'h00;
         end else if (step_end) begin
            frm_q <= 5'h00;
            vol_q <= (vol_q < vol_tgt) ? vol_q + 12'h1 : vol_q - 12'h1;
         end else if (frame_tick) begin
            frm_q <= frm_q + 5'h1;
         end
      end
   end

   assign hp_outputs_enable      = hp_en_q;
   assign speaker_outputs_enable = spk_en_q;
   assign volume_level           = vol_q;
   assign ramp_busy              = busy_q;
endmodule : pems_device
`default_nettype wire

// *** verilog/pems_pkg.sv ***
// Constants shared by the amplifier sequencer and its controller
package pems_pkg;
   // ----------------------------------------
   // Clock and times
   // ----------------------------------------
   localparam int  CLK_MHZ          = 250;
   localparam int  T_PD_DELAY_US    = 725;
   localparam int  PD_DELAY_CYC     = T_PD_DELAY_US * CLK_MHZ;
   localparam int  T_STARTUP_MAX_US = 650;
   localparam int  STARTUP_CYC      = T_STARTUP_MAX_US * CLK_MHZ;
   localparam int  T_PD_PULSE_US    = 1;
   localparam int  PD_PULSE_CYC     = T_PD_PULSE_US * CLK_MHZ;
   localparam int  T_ERR_PULSE_NS   = 350;
   localparam int  ERR_PULSE_CYC    = (T_ERR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int  T_HP_PULSE_NS    = 350;
   localparam int  HP_PULSE_CYC     = (T_HP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int  T_ERR_HOLD_MS    = 300;
   localparam int  ERR_HOLD_CYC     = T_ERR_HOLD_MS * 1000 * CLK_MHZ;
   localparam real T_SWITCH_MIN_MS  = 0.2;
   localparam int  SW_UNIT_CYC      = int'(T_SWITCH_MIN_MS * 1000.0 * CLK_MHZ);
   localparam int  T_RESET_MIN_US   = 100;
   localparam int  RESET_MIN_CYC    = T_RESET_MIN_US * CLK_MHZ;
   // ----------------------------------------
   // Device registers
   // ----------------------------------------
   localparam logic [7:0] REG_HP_CFG      = 8'h05;
   localparam logic [7:0] REG_VOL_CFG     = 8'h0E;
   localparam logic [7:0] REG_START_STOP  = 8'h1A;
   localparam logic [7:0] HP_CFG_RST      = 8'h10;
   localparam logic [7:0] VOL_CFG_RST     = 8'h02;
   localparam logic [7:0] START_STOP_RST  = 8'h00;
   localparam int         HP_DISABLE_BIT  = 4;
   localparam logic [11:0] VOL_STEPS_BASE = 12'h100;
   localparam logic [4:0] STEP_FR_LOW     = 5'h04;
   localparam logic [4:0] STEP_FR_MID     = 5'h08;
   localparam logic [4:0] STEP_FR_HIGH    = 5'h10;
   typedef enum logic [1:0] {
      RATE_UPTO_48K = 2'h0,
      RATE_UPTO_96K = 2'h1,
      RATE_ABOVE_96K = 2'h2
   } pems_rate_t;
   // ----------------------------------------
   // Controller registers on APB
   // ----------------------------------------
   localparam logic [7:0] CTL_CTRL     = 8'h00;
   localparam logic [7:0] CTL_REG_ACC  = 8'h04;
   localparam logic [7:0] CTL_STATUS   = 8'h08;
   localparam logic [7:0] CTL_IRQ_STAT = 8'h0C;
   localparam logic [7:0] CTL_IRQ_MASK = 8'h10;
   localparam int CTRL_RUN  = 0;
   localparam int CTRL_PD   = 1;
   localparam int CTRL_HP   = 2;
   localparam int ACC_READ  = 16;
   localparam int IRQ_FAULT     = 0;
   localparam int IRQ_STAGE_OFF = 1;
   localparam int IRQ_SAFE_OFF  = 2;
   localparam int IRQ_STAGE_ON  = 3;
endpackage : pems_pkg

// *** verilog/pems_if.sv ***
// Control pins between the system controller and the amplifier sequencer
`timescale 1ns/100ps
`default_nettype none
interface pems_if;
   logic       reset_n;
   logic       power_down_request_n;
   logic       back_end_error_n;
   logic       headphone_select;
   logic       reg_we;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       power_stage_enable;
   logic       fault_o;
   logic       fault_oe;
   wire        fault_n_line;

   // Open-drain line with pull-up
   assign fault_n_line = fault_oe ? fault_o : 1'b1;

   modport dev (
      input  reset_n, power_down_request_n, back_end_error_n, headphone_select,
      input  reg_we, reg_addr, reg_wdata,
      output reg_rdata, power_stage_enable, fault_o, fault_oe
   );
   modport ctl (
      output reset_n, power_down_request_n, back_end_error_n, headphone_select,
      output reg_we, reg_addr, reg_wdata,
      input  reg_rdata, power_stage_enable, fault_n_line
   );
endinterface : pems_if
`default_nettype wire

// *** verilog/pems_controller.sv ***
// System controller: APB registers driving the amplifier control pins
`timescale 1ns/100ps
`default_nettype none
module pems_controller #(
   parameter int unsigned PD_DELAY_CYC  = pems_pkg::PD_DELAY_CYC,
   parameter int unsigned SW_UNIT_CYC   = pems_pkg::SW_UNIT_CYC,
   parameter int unsigned RESET_MIN_CYC = pems_pkg::RESET_MIN_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Error source and interrupt
   input  wire logic        back_end_error_req,
   output logic             irq,
   // Control pins
   pems_if.ctl              link
);
   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   function automatic logic [15:0] sat_inc(input logic [15:0] c, input int unsigned lim);
      sat_inc = (32'(c) < lim) ? c + 16'h1 : c;
   endfunction : sat_inc

   logic [2:0]  ctrl_q;
   logic [3:0]  sts_q, mask_q;
   logic [7:0]  acc_addr_q, acc_data_q, stop_q;
   logic        we_q, rdy_q, err_q, irq_q;
   logic [31:0] rdata_q, off_cnt_q;
   logic        rst_n_q, pd_n_q, err_n_q, hp_q;
   logic [15:0] rst_cnt_q, pd_cnt_q, err_cnt_q, hp_cnt_q;
   logic        stage_q, fault_q, safe_q;
   wire access  = psel && penable && !rdy_q;
   wire wr      = access && pwrite;
   wire rd      = access && !pwrite;
   wire a_ctrl  = paddr == pems_pkg::CTL_CTRL;
   wire a_acc   = paddr == pems_pkg::CTL_REG_ACC;
   wire a_sts   = paddr == pems_pkg::CTL_STATUS;
   wire a_irq   = paddr == pems_pkg::CTL_IRQ_STAT;
   wire a_mask  = paddr == pems_pkg::CTL_IRQ_MASK;
   wire mapped  = a_ctrl || a_acc || a_sts || a_irq || a_mask;
   wire fault_now = !link.fault_n_line;
   wire [31:0] safe_lim = 32'(PD_DELAY_CYC) + 32'((33'(stop_q) + 33'h1) * 33'(SW_UNIT_CYC));
   wire safe_now = !pd_n_q && off_cnt_q >= safe_lim;
   wire [3:0] evt = {link.power_stage_enable && !stage_q, safe_now && !safe_q,
                     !link.power_stage_enable && stage_q, fault_now && !fault_q};
   wire [3:0] sts_d = (rd && a_irq) ? evt : (sts_q | evt);
   wire [31:0] rdata_d = a_ctrl ? {29'h0, ctrl_q} :
                         a_acc  ? {16'h0, acc_addr_q, link.reg_rdata} :
                         a_sts  ? {27'h0, pd_n_q, rst_n_q, safe_q, fault_q, stage_q} :
                         a_irq  ? {28'h0, sts_q} :
                         a_mask ? {28'h0, mask_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q     <= 3'h0;
         mask_q     <= 4'h0;
         sts_q      <= 4'h0;
         acc_addr_q <= 8'h00;
         acc_data_q <= 8'h00;
         stop_q     <= pems_pkg::START_STOP_RST;
         we_q       <= 1'b0;
         rdy_q      <= 1'b0;
         err_q      <= 1'b0;
         rdata_q    <= 32'h0;
         irq_q      <= 1'b0;
         stage_q    <= 1'b0;
         fault_q    <= 1'b0;
         safe_q     <= 1'b0;
      end else begin
         rdy_q   <= access;
         err_q   <= access && !mapped;
         rdata_q <= rd ? rdata_d : 32'h0;
         we_q    <= wr && a_acc && !pwdata[pems_pkg::ACC_READ];
         if (wr && a_ctrl) ctrl_q <= pwdata[2:0];
         if (wr && a_mask) mask_q <= pwdata[3:0];
         if (wr && a_acc) begin
            acc_addr_q <= pwdata[15:8];
            acc_data_q <= pwdata[7:0];
         end
         if (wr && a_acc && !pwdata[pems_pkg::ACC_READ] &&
             pwdata[15:8] == pems_pkg::REG_START_STOP) stop_q <= pwdata[7:0];
         sts_q   <= sts_d;
         irq_q   <= |(sts_d & mask_q);
         stage_q <= link.power_stage_enable;
         fault_q <= fault_now;
         safe_q  <= safe_now;
      end
   end

   // ----------------------------------------
   // Pin drivers with least pulse lengths
   // ----------------------------------------
   wire rst_ok = 32'(rst_cnt_q) >= RESET_MIN_CYC;
   wire pd_ok  = 32'(pd_cnt_q) >= pems_pkg::PD_PULSE_CYC;
   wire err_ok = 32'(err_cnt_q) >= pems_pkg::ERR_PULSE_CYC;
   wire hp_ok  = 32'(hp_cnt_q) >= pems_pkg::HP_PULSE_CYC;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_n_q   <= 1'b0;
         pd_n_q    <= 1'b1;
         err_n_q   <= 1'b1;
         hp_q      <= 1'b0;
         rst_cnt_q <= 16'h0;
         pd_cnt_q  <= 16'h0;
         err_cnt_q <= 16'h0;
         hp_cnt_q  <= 16'h0;
         off_cnt_q <= 32'h0;
      end else begin
         rst_cnt_q <= rst_n_q ? 16'h0 : sat_inc(rst_cnt_q, RESET_MIN_CYC);
         if (!rst_n_q) rst_n_q <= ctrl_q[pems_pkg::CTRL_RUN] && rst_ok;
         else rst_n_q <= ctrl_q[pems_pkg::CTRL_RUN];
         pd_cnt_q <= pd_n_q ? 16'h0 : sat_inc(pd_cnt_q, pems_pkg::PD_PULSE_CYC);
         if (pd_n_q) pd_n_q <= !ctrl_q[pems_pkg::CTRL_PD];
         else if (pd_ok) pd_n_q <= !ctrl_q[pems_pkg::CTRL_PD];
         err_cnt_q <= err_n_q ? 16'h0 : sat_inc(err_cnt_q, pems_pkg::ERR_PULSE_CYC);
         if (err_n_q) err_n_q <= !back_end_error_req;
         else if (err_ok) err_n_q <= !back_end_error_req;
         hp_cnt_q <= (hp_q != ctrl_q[pems_pkg::CTRL_HP] && hp_ok) ? 16'h0 :
                     sat_inc(hp_cnt_q, pems_pkg::HP_PULSE_CYC);
         if (hp_ok) hp_q <= ctrl_q[pems_pkg::CTRL_HP];
         off_cnt_q <= pd_n_q ? 32'h0 : (safe_now ? off_cnt_q : off_cnt_q + 32'h1);
      end
   end

   assign prdata                    = rdata_q;
   assign pready                    = rdy_q;
   assign pslverr                   = err_q;
   assign irq                       = irq_q;
   assign link.reset_n              = rst_n_q;
   assign link.power_down_request_n = pd_n_q;
   assign link.back_end_error_n     = err_n_q;
   assign link.headphone_select     = hp_q;
   assign link.reg_we               = we_q;
   assign link.reg_addr             = acc_addr_q;
   assign link.reg_wdata            = acc_data_q;
endmodule : pems_controller
`default_nettype wire

// *** bench/pems_link_sva.sv ***
// Assertions on the control pins between controller and sequencer
`timescale 1ns/100ps
`default_nettype none
module pems_link_sva #(
   parameter int unsigned PD_DELAY_CYC = 50,
   parameter int unsigned ERR_HOLD_CYC = 60
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link pins
   input wire logic reset_n,
   input wire logic power_down_request_n,
   input wire logic back_end_error_n,
   input wire logic headphone_select,
   input wire logic power_stage_enable,
   input wire logic fault_n_line
);
   int pd_q, err_q, hp_q, off_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles spent at the low level; for headphone_select, cycles since its last change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_q  <= 0;
         err_q <= 0;
         hp_q  <= 0;
         off_q <= 0;
      end else begin
         pd_q  <= power_down_request_n ? 0 : pd_q + 1;
         err_q <= back_end_error_n ? 0 : err_q + 1;
         hp_q  <= $changed(headphone_select) ? 0 : hp_q + 1;
         off_q <= power_stage_enable ? 0 : off_q + 1;
      end
   end
   pd_delay_a: assert property ($fell(power_stage_enable) && !power_down_request_n
      && back_end_error_n && fault_n_line |-> pd_q inside {[PD_DELAY_CYC-1:PD_DELAY_CYC+3]})
      else $error("stage off at wrong time");
   err_drop_a: assert property ($fell(back_end_error_n) |-> ##[1:3] !power_stage_enable)
      else $error("stage not stopped on error");
   err_hold_a: assert property ($rose(power_stage_enable) |-> off_q >= ERR_HOLD_CYC - 1)
      else $error("stage low too short");
   err_release_a: assert property ($rose(power_stage_enable)
      |-> back_end_error_n && $past(back_end_error_n)) else $error("released under error");
   reset_off_a: assert property (!reset_n ##1 !reset_n |-> !power_stage_enable)
      else $error("stage on in reset");
   fault_high_a: assert property (!reset_n [*2] |-> fault_n_line)
      else $error("fault low in reset");
   pd_pulse_a: assert property ($rose(power_down_request_n)
      |-> pd_q >= pems_pkg::PD_PULSE_CYC - 1) else $error("power-down pulse short");
   err_pulse_a: assert property ($rose(back_end_error_n)
      |-> err_q >= pems_pkg::ERR_PULSE_CYC - 1) else $error("error pulse short");
   hp_pulse_a: assert property ($changed(headphone_select)
      |-> hp_q >= pems_pkg::HP_PULSE_CYC - 1) else $error("select pulse short");
   cover property ($fell(power_stage_enable) && !power_down_request_n);
   cover property ($rose(power_stage_enable) && off_q > ERR_HOLD_CYC);
   cover property ($changed(headphone_select));
endmodule : pems_link_sva
`default_nettype wire

// *** bench/pems_tb_top.sv ***
// Testbench joining controller and sequencer through their control pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < (n)) begin @(posedge pclk); k++; end end
module pems_tb_top;
   localparam int PD = 50, EH = 60, SW = 20, RM = 30, SU = 40;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, back_end_error_req;
   logic        frame_tick, gate_drive_supply_ok, fault_event, bridge_low_z;
   logic        hp_outputs_enable, speaker_outputs_enable, regulator_voltage_ok, ramp_busy;
   logic [1:0]  rate_class;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [11:0] volume_level;
   logic [32:0] expq[$];
   logic [7:0]  ra [3] = '{8'h05, 8'h0E, 8'h1A};
   logic [7:0]  rv [3] = '{pems_pkg::HP_CFG_RST, pems_pkg::VOL_CFG_RST, pems_pkg::START_STOP_RST};
   int          fails, n_compared, k, seed, cyc;
   pems_if link_if ();
   pems_device #(.PD_DELAY_CYC(PD), .STARTUP_CYC(SU), .ERR_HOLD_CYC(EH), .SW_UNIT_CYC(SW))
      pems_device_inst (.pclk, .presetn, .link(link_if), .frame_tick, .rate_class,
      .gate_drive_supply_ok, .regulator_voltage_ok, .fault_event, .soft_mute(1'b0),
      .bridge_low_z, .hp_outputs_enable, .speaker_outputs_enable, .volume_level, .ramp_busy);
   pems_controller #(.PD_DELAY_CYC(PD), .SW_UNIT_CYC(SW), .RESET_MIN_CYC(RM))
      pems_controller_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .back_end_error_req, .irq, .link(link_if));
   pems_link_sva #(.PD_DELAY_CYC(PD), .ERR_HOLD_CYC(EH)) pems_link_sva_inst (.pclk, .presetn,
      .reset_n(link_if.reset_n), .power_down_request_n(link_if.power_down_request_n),
      .back_end_error_n(link_if.back_end_error_n), .headphone_select(link_if.headphone_select),
      .power_stage_enable(link_if.power_stage_enable), .fault_n_line(link_if.fault_n_line));
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      if (!w) expq.push_back(e);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      `WAITC(pready === 1'b1, 50)
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Frame ticks, run limit and read-data checker
   always @(posedge pclk) begin
      frame_tick <= ~frame_tick;
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fails++;
         summarize();
      end
      if (psel && penable && pready && !pwrite) `CHK({pslverr, prdata}, expq.pop_front())
   end
   initial begin
      {seed, cyc, fails, n_compared} = {32'd49281, 96'd0};
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {frame_tick, back_end_error_req, fault_event} = '0;
      {gate_drive_supply_ok, regulator_voltage_ok} = 2'h3;
      rate_class = 2'($unsigned($random(seed)) % 3);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, 8'h00, 32'h1, '0);
      `WAITC(link_if.power_stage_enable === 1'b1, RM + SU + 20)
      `CHK(link_if.power_stage_enable, 1'b1)
      `CHK(hp_outputs_enable, 1'b0)
      apb(1'b0, 8'h08, '0, 33'h19);
      apb(1'b0, 8'h0C, '0, 33'h8);
      apb(1'b0, 8'h0C, '0, 33'h0);
      apb(1'b0, 8'h14, '0, {1'b1, 32'h0});
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'h04, {15'h0, 1'b1, ra[i], 8'h00}, '0);
         apb(1'b0, 8'h04, '0, {17'h0, ra[i], rv[i]});
      end
      apb(1'b1, 8'h04, 32'h0E00, '0);
      apb(1'b1, 8'h10, 32'h2, '0);
      apb(1'b1, 8'h00, 32'h3, '0);
      `WAITC(irq === 1'b1, PD + 20)
      `CHK(k >= PD - 8, 1'b1)
      apb(1'b0, 8'h0C, '0, 33'h2);
      `CHK(irq, 1'b0)
      repeat (SW + 20) @(posedge pclk);
      apb(1'b0, 8'h08, '0, 33'h0C);
      apb(1'b1, 8'h00, 32'h1, '0);
      `WAITC(link_if.power_stage_enable === 1'b1, 400)
      `CHK(link_if.power_stage_enable, 1'b1)
      for (int i = 0; i < 2; i++) begin
         back_end_error_req <= 1'b1;
         `WAITC(link_if.power_stage_enable === 1'b0, 10)
         `CHK(k <= 5, 1'b1)
         repeat (i ? 200 : 1 + $unsigned($random(seed)) % 40) @(posedge pclk);
         `CHK(link_if.power_stage_enable, 1'b0)
         back_end_error_req <= 1'b0;
         `WAITC(link_if.power_stage_enable === 1'b1, EH + 100)
         `CHK(link_if.power_stage_enable, 1'b1)
      end
      apb(1'b1, 8'h00, 32'h5, '0);
      `WAITC(hp_outputs_enable === 1'b1, 30000)
      `CHK(k >= SW, 1'b1)
      `CHK(speaker_outputs_enable, 1'b0)
      `CHK(ramp_busy, 1'b1)
      `WAITC(volume_level === 12'h100, 9000)
      `CHK(k > 500 * (4 << rate_class) && k < 520 * (4 << rate_class), 1'b1)
      apb(1'b1, 8'h04, 32'h0500, '0);
      apb(1'b1, 8'h00, 32'h1, '0);
      `WAITC(speaker_outputs_enable === 1'b1, 30000)
      `CHK(hp_outputs_enable, 1'b1)
      apb(1'b1, 8'h10, 32'h1, '0);
      fault_event <= 1'b1;
      gate_drive_supply_ok <= 1'b0;
      repeat (5) @(posedge pclk);
      `CHK(irq, 1'b1)
      `CHK(bridge_low_z, 1'b1)
      apb(1'b1, 8'h00, 32'h0, '0);
      repeat (3) @(posedge pclk);
      `CHK(link_if.fault_n_line, 1'b1)
      gate_drive_supply_ok <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(bridge_low_z, 1'b0)
      regulator_voltage_ok <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(bridge_low_z, 1'b1)
      summarize();
   end
endmodule : pems_tb_top
`default_nettype wire
